// [logic/wwdc_pkg.sv]
// Package: register map, field layout and timing constants of the watchdog control block
package wwdc_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [11:0] IDX_CON0  = 12'h080c;
  localparam logic [11:0] IDX_CON1  = 12'h080d;
  localparam logic [11:0] IDX_PSL   = 12'h080e;
  localparam logic [11:0] IDX_PSH   = 12'h080f;
  localparam logic [11:0] IDX_TMR   = 12'h0810;
  localparam logic [11:0] IDX_CFG   = 12'h0811;
  localparam logic [11:0] IDX_CMD   = 12'h0812;
  localparam logic [11:0] IDX_ISTAT = 12'h0813;
  localparam logic [11:0] IDX_IEN   = 12'h0814;
  localparam logic [11:0] IDX_ICLR  = 12'h0815;

  // Field positions
  localparam int CON0_SEN_BIT = 0;
  localparam int CON0_PS_LSB  = 1;
  localparam int CON1_WIN_LSB = 0;
  localparam int CON1_CS_LSB  = 4;
  localparam int CMD_CLR_BIT  = 0;
  localparam int CMD_WV_BIT   = 1;
  localparam int IRQ_TO_BIT   = 0;
  localparam int IRQ_WV_BIT   = 1;

  // Codes and values after reset
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SW     = 2'h1;
  localparam logic [4:0] CPS_SW      = 5'h1f;
  localparam logic [4:0] PS_DEFAULT  = 5'h0b;
  localparam logic [4:0] PS_MAX_CODE = 5'h12;
  localparam logic [2:0] CCS_SW      = 3'h7;
  localparam logic [2:0] CS_LF       = 3'h0;
  localparam logic [2:0] CS_MF       = 3'h1;
  localparam logic [2:0] CWS_SW      = 3'h7;
  localparam logic [2:0] WIN_FULL    = 3'h7;

  // Configuration word as held after reset
  localparam logic [12:0] CFG_RESET  = 13'h1fff;

  // Oscillator rates and derived tick dividers at the 10 MHz bus clock
  localparam int PCLK_HZ  = 10_000_000;
  localparam int LF_HZ    = 31_000;
  localparam int MF_HZ    = 31_250;
  localparam int LF_DIV_I = PCLK_HZ / LF_HZ;
  localparam int MF_DIV_I = PCLK_HZ / MF_HZ;
  localparam logic [8:0] LF_DIV = 9'(LF_DIV_I - 1);
  localparam logic [8:0] MF_DIV = 9'(MF_DIV_I - 1);

  typedef struct packed {
    logic [2:0] cws;   // Window reset source / lock
    logic [2:0] ccs;   // Clock select reset source / lock
    logic [4:0] cps;   // Prescale reset source / lock
    logic [1:0] mode;  // Enable mode
  } wwdc_cfg_t;

  typedef struct packed {
    logic wv;          // Window violation
    logic to;          // Time-out
  } wwdc_irq_t;
endpackage

// [logic/wwdc_top.sv]
// Windowed watchdog control block: APB registers, prescaler, window counter, arming
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module wwdc_top
  import wwdc_pkg::*;
#(
  parameter int ADDR_W = 14
) (
  input  wire  logic              pclk,      // Bus clock, 10 MHz
  input  wire  logic              presetn,   // Asynchronous reset, active low
  input  wire  logic              psel,      // APB select
  input  wire  logic              penable,   // APB access phase
  input  wire  logic              pwrite,    // APB direction
  input  wire  logic [ADDR_W-1:0] paddr,     // APB byte address
  input  wire  logic [31:0]       pwdata,    // APB write data
  input  wire  logic [3:0]        pstrb,     // APB byte strobes
  output logic                    pready,    // APB ready
  output logic [31:0]             prdata,    // APB read data
  output logic                    pslverr,   // APB error on unmapped address
  output logic                    wdt_rst,   // One-cycle watchdog reset request
  output logic                    irq        // Level interrupt
);
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must be 14..32");
  end

  // Register state
  wwdc_cfg_t   cfg_q;
  logic        sen_q;
  logic [4:0]  ps_q;
  logic [2:0]  cs_q;
  logic [2:0]  win_q;
  logic        load_q;
  logic        armed_q;
  logic        wv_n_q;
  wwdc_irq_t   ists_q;
  wwdc_irq_t   ien_q;
  logic [17:0] prescale_count_q;
  logic [4:0]  tmr_q;
  logic [8:0]  div_q;
  logic        tick_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        wdt_rst_q;
  logic        irq_q;

  // Bus decode
  logic [11:0] idx;
  logic        aligned;
  logic        setup;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [31:0] rd_d;

  assign idx     = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'h0) && ((paddr >> 14) == '0);
  assign setup   = psel && !penable && !pready_q;
  assign acc     = psel && penable && pready_q;
  assign wr      = acc && pwrite && pstrb[0] && !pslverr_q;
  assign rd      = acc && !pwrite && !pslverr_q;

  always_comb begin
    mapped = aligned;
    rd_d   = 32'h0000_0000;
    case (idx)
      IDX_CON0:  rd_d[5:0] = {ps_q, sen_q};
      IDX_CON1:  rd_d[6:0] = {cs_q, 1'b0, win_q};
      IDX_PSL:   rd_d[7:0] = prescale_count_q[7:0];
      IDX_PSH:   rd_d[7:0] = prescale_count_q[15:8];
      IDX_TMR:   rd_d[7:0] = {tmr_q, armed_q, prescale_count_q[17:16]};
      IDX_CFG:   rd_d[12:0] = cfg_q;
      IDX_CMD:   rd_d[CMD_WV_BIT] = wv_n_q;
      IDX_ISTAT: rd_d[1:0] = ists_q;
      IDX_IEN:   rd_d[1:0] = ien_q;
      IDX_ICLR:  rd_d = 32'h0000_0000;
      default:   mapped = 1'b0;
    endcase
  end

  // APB slave: data latched in setup, one access cycle with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= !mapped;
        prdata_q  <= mapped ? rd_d : 32'h0000_0000;
      end
    end
  end

  // Watchdog control decode
  logic        wr_con0;
  logic        wr_con1;
  logic        wr_cfg;
  logic        clr_cmd;
  logic        wdt_en;
  logic        windowed;
  logic        win_open;
  logic        viol;
  logic        timeout;
  logic [4:0]  ps_eff;
  logic [17:0] ps_lim;
  logic [8:0]  div_lim;
  logic        cnt_clr;

  assign wr_con0  = wr && idx == IDX_CON0;
  assign wr_con1  = wr && idx == IDX_CON1;
  assign wr_cfg   = wr && idx == IDX_CFG;
  assign clr_cmd  = wr && idx == IDX_CMD && pwdata[CMD_CLR_BIT];
  assign wdt_en   = (cfg_q.mode == MODE_SW) ? sen_q
                                            : cfg_q.mode[1];
  assign windowed = win_q != WIN_FULL;
  assign win_open = tmr_q >= {~win_q, 2'b00};
  assign viol     = clr_cmd && windowed && (!armed_q || !win_open);
  assign ps_eff   = (ps_q > PS_MAX_CODE) ? 5'h00 : ps_q;
  assign ps_lim   = 18'((19'h0_0001 << ps_eff) - 19'h0_0001);
  assign div_lim  = (cs_q == CS_MF) ? MF_DIV : LF_DIV;
  assign timeout  = wdt_en && tick_q && prescale_count_q == ps_lim && tmr_q == 5'h1f;
  assign cnt_clr  = !wdt_en || load_q || wr_con0 || wr_con1
                    || clr_cmd || timeout;

  // Configuration word and reload pulse after reset or config write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q  <= CFG_RESET;
      load_q <= 1'b1;
    end else begin
      load_q <= wr_cfg;
      if (wr_cfg) cfg_q <= pwdata[12:0];
    end
  end

  // Control zero: enable and prescale select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q <= 1'b0;
      ps_q  <= PS_DEFAULT;
    end else if (load_q) begin
      sen_q <= 1'b0;
      ps_q  <= (cfg_q.cps == CPS_SW) ? PS_DEFAULT : cfg_q.cps;
    end else if (wr_con0) begin
      sen_q <= pwdata[CON0_SEN_BIT];
      if (cfg_q.cps == CPS_SW) ps_q <= pwdata[CON0_PS_LSB +: 5];
    end
  end

  // Control one: clock select and window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q  <= CS_LF;
      win_q <= WIN_FULL;
    end else if (load_q) begin
      cs_q  <= (cfg_q.ccs == CCS_SW) ? CS_LF : cfg_q.ccs;
      win_q <= cfg_q.cws;
    end else if (wr_con1) begin
      if (cfg_q.ccs == CCS_SW) cs_q <= pwdata[CON1_CS_LSB +: 3];
      if (cfg_q.cws == CWS_SW) win_q <= pwdata[CON1_WIN_LSB +: 3];
    end
  end

  // Oscillator tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q >= div_lim;
      div_q  <= (div_q >= div_lim) ? 9'h000 : div_q + 9'h001;
    end
  end

  // Prescaler and window counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count_q <= 18'h0_0000;
      tmr_q   <= 5'h00;
    end else if (cnt_clr) begin
      prescale_count_q <= 18'h0_0000;
      tmr_q   <= 5'h00;
    end else if (tick_q) begin
      if (prescale_count_q == ps_lim) begin
        prescale_count_q <= 18'h0_0000;
        tmr_q   <= tmr_q + 5'h01;
      end else begin
        prescale_count_q <= prescale_count_q + 18'h0_0001;
      end
    end
  end

  // Arming: read of control zero arms, any clear disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (rd && idx == IDX_CON0) begin
      armed_q <= 1'b1;
    end else if (clr_cmd || cnt_clr) begin
      armed_q <= 1'b0;
    end
  end

  // Violation flag and reset request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wv_n_q    <= 1'b1;
      wdt_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= viol || timeout;
      if (viol) wv_n_q <= 1'b0;
      else if (wr && idx == IDX_CMD && pwdata[CMD_WV_BIT]) wv_n_q <= 1'b1;
    end
  end

  // Interrupt status, enable and clear; a set wins over a clear
  wwdc_irq_t ev;
  wwdc_irq_t iclr;
  assign ev.to   = timeout;
  assign ev.wv   = viol;
  assign iclr    = (wr && idx == IDX_ICLR) ? pwdata[1:0] : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= '0;
      ien_q  <= '0;
      irq_q  <= 1'b0;
    end else begin
      ists_q <= (ists_q & ~iclr) | ev;
      if (wr && idx == IDX_IEN) ien_q <= pwdata[1:0];
      irq_q  <= |(((ists_q & ~iclr) | ev) & ien_q);
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign wdt_rst = wdt_rst_q;
  assign irq     = irq_q;

  // Checks
  en_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q.mode == MODE_OFF |-> !wdt_en) else $error("watchdog on in mode 00");
  tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> !tick_q [*8]) else $error("tick too frequent");
  load_ps_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_q && cfg_q.cps == CPS_SW |=> ps_q == PS_DEFAULT) else $error("bad prescale load");
  ps_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !load_q && cfg_q.cps != CPS_SW |=> $stable(ps_q)) else $error("locked prescale moved");
  cs_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !load_q && cfg_q.ccs != CCS_SW |=> $stable(cs_q)) else $error("locked clock moved");
  win_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    !load_q && cfg_q.cws != CWS_SW |=> $stable(win_q)) else $error("locked window moved");
  viol_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_cmd && windowed && !armed_q |=> wdt_rst_q && !wv_n_q ##1 !wdt_rst_q)
    else $error("unarmed clear not punished");
  wr_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_con0 || wr_con1 |=> prescale_count_q == 18'h0_0000 && tmr_q == 5'h00)
    else $error("control write left count");
  arm_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && idx == IDX_CON0 |=> armed_q) else $error("read did not arm");

  // Enable gating and tick source
  en_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q.mode == MODE_SW |-> wdt_en == sen_q) else $error("software enable ignored");
  en_hw_a: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q.mode[1] |-> wdt_en) else $error("watchdog off in mode 1x");
  en_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wdt_en |=> prescale_count_q == 18'h0_0000 && tmr_q == 5'h00) else $error("disabled count moved");
  div_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    cs_q == CS_MF |-> div_lim == MF_DIV) else $error("medium source not selected");
  div_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    cs_q != CS_MF |-> div_lim == LF_DIV) else $error("low source not selected");
  div_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    div_q <= LF_DIV) else $error("divider out of range");

  // Reload and write locks
  ps_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_q && cfg_q.cps != CPS_SW |=> ps_q == $past(cfg_q.cps)) else $error("prescale not copied");
  ps_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_con0 && !load_q && cfg_q.cps == CPS_SW |=> ps_q == $past(pwdata[5:1]))
    else $error("prescale write lost");
  sen_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_q |=> !sen_q) else $error("enable bit not reset");
  cs_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_q && cfg_q.ccs == CCS_SW |=> cs_q == CS_LF) else $error("clock select not reset");
  cs_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_q && cfg_q.ccs != CCS_SW |=> cs_q == $past(cfg_q.ccs)) else $error("clock not copied");
  cs_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_con1 && !load_q && cfg_q.ccs == CCS_SW |=> cs_q == $past(pwdata[6:4]))
    else $error("clock write lost");
  win_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    load_q |=> win_q == $past(cfg_q.cws)) else $error("window not copied");
  win_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_con1 && !load_q && cfg_q.cws == CWS_SW |=> win_q == $past(pwdata[2:0]))
    else $error("window write lost");

  // Window and arming
  win_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    win_q == WIN_FULL |-> win_open && !windowed) else $error("full window not open");
  win_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    win_q == 3'h6 |-> win_open == (tmr_q >= 5'h04)) else $error("window 110 edge wrong");
  win_last_a: assert property (@(posedge pclk) disable iff (!presetn)
    win_q == 3'h0 |-> win_open == (tmr_q >= 5'h1c)) else $error("window 000 edge wrong");
  open_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_cmd && armed_q && win_open && !timeout |=> !wdt_rst_q) else $error("valid clear punished");
  closed_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_cmd && windowed && !win_open |=> wdt_rst_q && !wv_n_q) else $error("closed clear passed");
  clr_disarm_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr_cmd |=> !armed_q) else $error("clear left watchdog armed");
  wv_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    viol |=> ists_q.wv) else $error("violation status not set");

  // Prescale interval and read view
  ps_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    ps_q > PS_MAX_CODE |-> ps_lim == 18'h0_0000) else $error("reserved code not minimum");
  ps_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    ps_q == PS_MAX_CODE |-> ps_lim == 18'h3_ffff) else $error("largest ratio wrong");
  tmr_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && idx == IDX_TMR && aligned |=> prdata_q[2:0] == $past({armed_q, prescale_count_q[17:16]}))
    else $error("timer view wrong");
  psh_view_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && idx == IDX_PSH && aligned |=> prdata_q[7:0] == $past(prescale_count_q[15:8]))
    else $error("high prescale view wrong");
  map_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr_q && prdata_q == 32'h0000_0000) else $error("bad address taken");
  read_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && !tick_q && !cnt_clr |=> $stable(prescale_count_q)) else $error("read disturbed count");
  timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
    timeout |=> wdt_rst_q && tmr_q == 5'h00 && ists_q.to) else $error("time-out not handled");
endmodule

// [verif/windowed_watchdog_control_tb.sv]
// Self-checking bench for the windowed watchdog control registers over APB
`timescale 1ns/1ps
module windowed_watchdog_control_tb;
  import wwdc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, wdt_rst, irq, rerr;
  int          err_count, total_checks, base;
  int          rst_cnt = 0;
  localparam int TICK = LF_DIV_I;

  wwdc_top i_wwdc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .wdt_rst(wdt_rst), .irq(irq));

  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  // Counts watchdog reset pulses
  always @(posedge pclk) begin
    if (wdt_rst === 1'b1) rst_cnt <= rst_cnt + 1;
  end

  function automatic logic [13:0] a(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic final_report();
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [13:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      chk("pready", 1, 0);
      final_report();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1, a(idx), d);
  endtask

  task automatic rd(input string nm, input logic [11:0] idx, input logic [31:0] msk,
                    input logic [31:0] exp);
    apb(0, a(idx), 0);
    chk(nm, exp, rdata & msk);
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK + 20) @(posedge pclk);
  endtask

  // Waits up to lim cycles for a reset pulse after the snapshot in base
  task automatic exp_rst(input string nm, input int lim, input logic want);
    int n;
    n = 0;
    while (rst_cnt == base && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, want, rst_cnt != base);
    if (want && rst_cnt == base) final_report();
  endtask

  task automatic runs(input string nm, input logic want);
    ticks(3);
    apb(0, a(IDX_PSL), 0);
    chk(nm, want, |rdata[7:0]);
  endtask

  initial begin
    #(100_000 * 100);
    err_count++;
    final_report();
  end

  initial begin
    err_count = 0; total_checks = 0; base = 0;
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    rd("tmr_rst", IDX_TMR, 32'hffff_ffff, 0);
    rd("psl_rst", IDX_PSL, 32'hffff_ffff, 0);
    rd("con0_rst", IDX_CON0, 32'hffff_ffff, 32'h0000_0016);
    rd("con1_rst", IDX_CON1, 32'hffff_ffff, 32'h0000_0007);
    rd("armed", IDX_TMR, 32'hffff_ffff, 32'h0000_0004);
    apb(0, a(IDX_ICLR + 12'h001), 0);
    chk("unmapped", 32'h8000_0000, {rerr, rdata[30:0]});
    apb(1, a(IDX_CON0) | 14'h0001, 0);
    chk("misalign", 1, rerr);
    rd("con0_keep", IDX_CON0, 32'hffff_ffff, 32'h0000_0016);
    wr(IDX_CON0, 0);
    rd("con0_wr", IDX_CON0, 32'hffff_ffff, 0);
    wr(IDX_CON1, 32'h0000_0013);
    rd("con1_wr", IDX_CON1, 32'hffff_ffff, 32'h0000_0013);
    // Locked config: mode 01, prescale 00101, clock 000, window 010
    wr(IDX_CFG, 32'h0000_0815);
    rd("con0_cfg", IDX_CON0, 32'hffff_ffff, 32'h0000_000a);
    rd("con1_cfg", IDX_CON1, 32'hffff_ffff, 32'h0000_0002);
    wr(IDX_CON0, 32'h0000_003e);
    rd("ps_lock", IDX_CON0, 32'hffff_ffff, 32'h0000_000a);
    wr(IDX_CON1, 32'h0000_0077);
    rd("con1_lock", IDX_CON1, 32'hffff_ffff, 32'h0000_0002);
    runs("sen_off", 0);
    wr(IDX_CON0, 32'h0000_0001);
    runs("sen_on", 1);
    wr(IDX_CFG, 32'h0000_0814);
    wr(IDX_CON0, 32'h0000_0001);
    runs("mode0", 0);
    wr(IDX_CFG, 32'h0000_0816);
    runs("mode2", 1);
    // Windowed operation, everything software writable
    wr(IDX_CFG, 32'h0000_1ffd);
    wr(IDX_CON0, 32'h0000_0001);
    wr(IDX_CON1, 0);
    wr(IDX_IEN, 32'h0000_0003);
    base = rst_cnt;
    wr(IDX_CMD, 32'h0000_0001);
    exp_rst("unarmed_clr", 10, 1);
    rd("wv_flag", IDX_CMD, 32'h0000_0002, 0);
    rd("istat_wv", IDX_ISTAT, 32'h0000_0003, 32'h0000_0002);
    chk("irq_wv", 1, irq);
    rd("arm", IDX_CON0, 32'hffff_ffff, 32'h0000_0001);
    rd("armed2", IDX_TMR, 32'h0000_0004, 32'h0000_0004);
    base = rst_cnt;
    wr(IDX_CMD, 32'h0000_0001);
    exp_rst("closed_clr", 10, 1);
    wr(IDX_ICLR, 32'h0000_0003);
    rd("istat_clr", IDX_ISTAT, 32'h0000_0003, 0);
    chk("irq_clr", 0, irq);
    wr(IDX_CON1, 32'h0000_0006);
    ticks(6);
    rd("arm2", IDX_CON0, 32'hffff_ffff, 32'h0000_0001);
    base = rst_cnt;
    wr(IDX_CMD, 32'h0000_0001);
    exp_rst("open_clr", 10, 0);
    rd("tmr_clr", IDX_TMR, 32'h0000_00e4, 0);
    ticks(2);
    apb(0, a(IDX_TMR), 0);
    chk("tmr_runs", 1, |rdata[7:3]);
    wr(IDX_CON0, 32'h0000_0001);
    rd("wr_clears", IDX_TMR, 32'h0000_00f0, 0);
    // Time-out raises the interrupt, then mask and clear it
    wr(IDX_IEN, 32'h0000_0001);
    base = rst_cnt;
    exp_rst("timeout", 34 * TICK + 200, 1);
    rd("istat_to", IDX_ISTAT, 32'h0000_0001, 32'h0000_0001);
    chk("irq_to", 1, irq);
    wr(IDX_IEN, 0);
    rd("ien", IDX_IEN, 32'h0000_0003, 0);
    chk("irq_mask", 0, irq);
    wr(IDX_ICLR, 32'h0000_0001);
    rd("istat_to_clr", IDX_ISTAT, 32'h0000_0001, 0);
    final_report();
  end
endmodule
